// ===== design/uss_defines.vh
// Constants for the synchronous slave serial port: register byte offsets,
// field positions and reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
`ifndef USS_DEFINES_VH
`define USS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define USS_OFS_INTERRUPT_CONTROL   6'h00
`define USS_OFS_FLAGS_ONE           6'h04
`define USS_OFS_ENABLES_ONE         6'h08
`define USS_OFS_PRIORITY_ONE        6'h0c
`define USS_OFS_RX_STATUS_CONTROL   6'h10
`define USS_OFS_TX_HOLDING_BUFFER   6'h14
`define USS_OFS_TX_STATUS_CONTROL   6'h18
`define USS_OFS_BIT_RATE_DIVISOR    6'h1c
`define USS_OFS_RECEIVE_BUFFER      6'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define USS_GLOBAL_INT_EN_BIT       7
`define USS_PERIPH_INT_EN_BIT       6
`define USS_RX_COMPLETE_BIT         5
`define USS_TX_EMPTY_BIT            4
`define USS_PORT_EN_BIT             7
`define USS_RX_NINE_SEL_BIT         6
`define USS_SINGLE_RX_EN_BIT        5
`define USS_CONT_RX_EN_BIT          4
`define USS_ADDR_DETECT_BIT         3
`define USS_FRAMING_ERR_BIT         2
`define USS_OVERRUN_ERR_BIT         1
`define USS_RX_NINTH_BIT            0
`define USS_CLK_SRC_SEL_BIT         7
`define USS_TX_NINE_SEL_BIT         6
`define USS_TX_EN_BIT               5
`define USS_CLOCKED_MODE_BIT        4
`define USS_HIGH_SPEED_BIT          2
`define USS_SHIFT_EMPTY_BIT         1
`define USS_TX_NINTH_BIT            0

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define USS_RST_BYTE                8'h00
`define USS_RST_TX_STATUS           8'h02
`define USS_WORD_BITS_EIGHT         4'h8
`define USS_WORD_BITS_NINE          4'h9
`define USS_RESP_OKAY               2'h0
`define USS_RESP_SLVERR             2'h2

`endif

// ===== design/uss_sync_edge.v
// Pin synchroniser for the shift clock and data pins, with a falling-edge
// detector on the shift clock.
// Assumes both pins are asynchronous to clk and much slower than it.
`timescale 1ns/100ps

module uss_sync_edge
(
  input  wire clk,
  input  wire rst_b,
  input  wire ck_pin,
  input  wire dt_pin,
  output wire dt_sync,
  output wire ck_fall
);

  // Both stages of each pin live in that pin's own generate scope, so no vector has two drivers.
  wire [1:0] pin_vec = {dt_pin, ck_pin};
  wire [1:0] sync_vec;
  reg        ck_last_reg;

  // --------------------------------------------------------------------------
  // Two flip-flops per pin
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_sync
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= pin_vec[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_vec[i] = sync_reg;
    end
  endgenerate

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ck_last_reg <= 1'b0;
    else
      ck_last_reg <= sync_vec[0];
  end

  assign dt_sync = sync_vec[1];
  assign ck_fall = ck_last_reg & ~sync_vec[0];

endmodule // uss_sync_edge

// ===== design/uss_slave_port.v
// Overview of operation
// - Slave mode behaves as master, external clock.
// - First queued word moves straight into shifter.
// - Second word waits; empty flag stays clear.
// - After shift-out, reload shifter and set flag in same cycle.
// - Empty flag with enable raises wake interrupt.
// - Nine-bit transmit sends software-placed ninth bit.
// - Transmit enable; holding write starts transfer.
// - Single-receive enable is ignored in slave mode.
// - Continuous receive works while core sleeps.
// - Complete word moves to buffer; enabled wake.
// - Receive-complete flag sets; interrupt needs enable.
// - Status register gives ninth bit and errors.
// - Clearing continuous receive clears receive errors.
// - Empty flag clears by holding write or by transmit disable.
// - External party drives clock; device never does.
// - Shift-empty status reads set when shifter idle.
// - Continuous receive repeats until enable cleared.
//
// Top of the synchronous slave serial port. Assumes a 32-bit Avalon-MM
// master on clk and a slow external master driving the clock pin.
`timescale 1ns/100ps
`include "uss_defines.vh"

module uss_slave_port
(
  input  wire        clk,
  input  wire        rst_b,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        ck_in,
  output reg         ck_out,
  output reg         ck_oe,
  input  wire        dt_in,
  output reg         dt_out,
  output reg         dt_oe,
  output reg         wake_req,
  output reg         irq
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function [3:0] word_bits;
    input nine;
    begin
      word_bits = nine ? `USS_WORD_BITS_NINE : `USS_WORD_BITS_EIGHT;
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [7:0] int_ctrl_reg;
  reg  [7:0] enables_reg;
  reg  [7:0] priority_reg;
  reg  [7:0] rx_ctrl_reg;
  reg  [7:0] tx_ctrl_reg;
  reg  [7:0] divisor_reg;
  reg  [7:0] hold_reg;
  reg        hold_full_reg;
  reg        tx_empty_flag_reg;
  reg  [8:0] tsr_reg;
  reg  [3:0] tx_cnt_reg;
  reg        tsr_full_reg;
  reg  [8:0] rsr_reg;
  reg  [3:0] rx_cnt_reg;
  reg  [7:0] rx_buf_reg;
  reg        rx_ninth_reg;
  reg        rx_flag_reg;
  reg        overrun_reg;

  wire       dt_sync;
  wire       ck_fall;

  uss_sync_edge u_sync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .ck_pin  (ck_in),
    .dt_pin  (dt_in),
    .dt_sync (dt_sync),
    .ck_fall (ck_fall)
  );

  // --------------------------------------------------------------------------
  // Bus access qualification
  // --------------------------------------------------------------------------
  wire req     = avs_read | avs_write;
  wire accept  = req & ~avs_waitrequest;
  wire wr_lo   = accept & avs_write & avs_byteenable[0];
  wire rd_acc  = accept & avs_read;
  wire mapped  = hit(avs_address, `USS_OFS_INTERRUPT_CONTROL)
               | hit(avs_address, `USS_OFS_FLAGS_ONE)
               | hit(avs_address, `USS_OFS_ENABLES_ONE)
               | hit(avs_address, `USS_OFS_PRIORITY_ONE)
               | hit(avs_address, `USS_OFS_RX_STATUS_CONTROL)
               | hit(avs_address, `USS_OFS_TX_HOLDING_BUFFER)
               | hit(avs_address, `USS_OFS_TX_STATUS_CONTROL)
               | hit(avs_address, `USS_OFS_BIT_RATE_DIVISOR)
               | hit(avs_address, `USS_OFS_RECEIVE_BUFFER);

  wire wr_hold = wr_lo & hit(avs_address, `USS_OFS_TX_HOLDING_BUFFER);
  wire wr_rxc  = wr_lo & hit(avs_address, `USS_OFS_RX_STATUS_CONTROL);
  wire wr_txc  = wr_lo & hit(avs_address, `USS_OFS_TX_STATUS_CONTROL);
  wire rd_rbuf = rd_acc & hit(avs_address, `USS_OFS_RECEIVE_BUFFER);

  // --------------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------------
  // Master clock generation is not built; with the clock source bit set
  // the port simply stays idle rather than shift on a clock nobody drives.
  wire slave_on = rx_ctrl_reg[`USS_PORT_EN_BIT]
                & tx_ctrl_reg[`USS_CLOCKED_MODE_BIT]
                & ~tx_ctrl_reg[`USS_CLK_SRC_SEL_BIT];
  wire cont_rx  = rx_ctrl_reg[`USS_CONT_RX_EN_BIT];
  // Reception owns the data line whenever continuous receive is on.
  wire rx_on    = slave_on & cont_rx;
  wire tx_on    = slave_on & tx_ctrl_reg[`USS_TX_EN_BIT] & ~cont_rx;
  wire tx_nine  = tx_ctrl_reg[`USS_TX_NINE_SEL_BIT];
  wire rx_nine  = rx_ctrl_reg[`USS_RX_NINE_SEL_BIT];

  // --------------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------------
  wire load_tsr  = tx_on & hold_full_reg & ~tsr_full_reg;
  wire tx_last   = (tx_cnt_reg == 4'h1);
  wire tx_shift  = tx_on & tsr_full_reg & ck_fall;

  reg  hold_full_next;
  always @*
  begin
    hold_full_next = hold_full_reg;
    if (load_tsr)
      hold_full_next = 1'b0;
    if (wr_hold)
      hold_full_next = 1'b1;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_reg          <= `USS_RST_BYTE;
      hold_full_reg     <= 1'b0;
      tx_empty_flag_reg <= 1'b0;
      tsr_reg           <= 9'h000;
      tx_cnt_reg        <= 4'h0;
      tsr_full_reg      <= 1'b0;
    end
    else
    begin
      if (wr_hold)
        hold_reg <= avs_writedata[7:0];
      hold_full_reg <= hold_full_next;
      // Set only while the holding buffer is free, cleared by a fresh word
      // or by clearing the transmit enable; software writes to the flag register cannot touch it.
      tx_empty_flag_reg <= tx_ctrl_reg[`USS_TX_EN_BIT]
                         & ~hold_full_next;
      if (load_tsr)
      begin
        tsr_reg      <= {tx_ctrl_reg[`USS_TX_NINTH_BIT], hold_reg};
        tx_cnt_reg   <= word_bits(tx_nine);
        tsr_full_reg <= 1'b1;
      end
      else if (!tx_on)
      begin
        // Dropping the enable abandons a word in flight.
        tsr_full_reg <= 1'b0;
        tx_cnt_reg   <= 4'h0;
      end
      else if (tx_shift)
      begin
        tsr_reg    <= {1'b0, tsr_reg[8:1]};
        tx_cnt_reg <= tx_cnt_reg - 4'h1;
        if (tx_last)
          tsr_full_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------------
  wire       rx_shift = rx_on & ~overrun_reg & ck_fall;
  wire       rx_last  = (rx_cnt_reg == word_bits(rx_nine) - 4'h1);
  wire       rx_done  = rx_shift & rx_last;
  // A word finishing while the previous one is still unread is lost.
  wire       rx_lost  = rx_done & rx_flag_reg & ~rd_rbuf;
  wire       rx_keep  = rx_done & ~rx_lost;
  reg  [8:0] rx_word;

  always @*
  begin
    rx_word = rsr_reg;
    rx_word[rx_cnt_reg] = dt_sync;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsr_reg      <= 9'h000;
      rx_cnt_reg   <= 4'h0;
      rx_buf_reg   <= `USS_RST_BYTE;
      rx_ninth_reg <= 1'b0;
      rx_flag_reg  <= 1'b0;
      overrun_reg  <= 1'b0;
    end
    else
    begin
      if (!rx_on)
        rx_cnt_reg <= 4'h0;
      else if (rx_shift)
      begin
        rsr_reg    <= rx_word;
        rx_cnt_reg <= rx_last ? 4'h0 : rx_cnt_reg + 4'h1;
      end
      if (rx_keep)
      begin
        rx_buf_reg   <= rx_word[7:0];
        rx_ninth_reg <= rx_nine ? rx_word[8] : 1'b0;
      end
      // A completion in the same cycle as the buffer read wins.
      rx_flag_reg <= rx_keep | (rx_flag_reg & ~rd_rbuf);
      if (!cont_rx)
        overrun_reg <= 1'b0;
      else if (rx_lost)
        overrun_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      int_ctrl_reg <= `USS_RST_BYTE;
      enables_reg  <= `USS_RST_BYTE;
      priority_reg <= `USS_RST_BYTE;
      rx_ctrl_reg  <= `USS_RST_BYTE;
      tx_ctrl_reg  <= `USS_RST_BYTE;
      divisor_reg  <= `USS_RST_BYTE;
    end
    else
    begin
      if (wr_lo & hit(avs_address, `USS_OFS_INTERRUPT_CONTROL))
        int_ctrl_reg <= avs_writedata[7:0];
      if (wr_lo & hit(avs_address, `USS_OFS_ENABLES_ONE))
        enables_reg <= avs_writedata[7:0];
      if (wr_lo & hit(avs_address, `USS_OFS_PRIORITY_ONE))
        priority_reg <= avs_writedata[7:0];
      if (wr_lo & hit(avs_address, `USS_OFS_BIT_RATE_DIVISOR))
        divisor_reg <= avs_writedata[7:0];
      // Error and ninth-bit fields are status; only control bits store.
      if (wr_rxc)
        rx_ctrl_reg <= {avs_writedata[7:3], 3'b000};
      // The shift-empty bit is status and is never stored.
      if (wr_txc)
        tx_ctrl_reg <= {avs_writedata[7:4], 1'b0, avs_writedata[2],
                        1'b0, avs_writedata[0]};
    end
  end

  // --------------------------------------------------------------------------
  // Read data assembly
  // --------------------------------------------------------------------------
  wire [7:0] flags_view = {2'b00, rx_flag_reg, tx_empty_flag_reg, 4'h0};
  wire [7:0] rxc_view   = {rx_ctrl_reg[7:3], 1'b0, overrun_reg,
                           rx_ninth_reg};
  wire [7:0] txc_view   = {tx_ctrl_reg[7:2], ~tsr_full_reg,
                           tx_ctrl_reg[0]};
  reg  [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    case (avs_address)
      `USS_OFS_INTERRUPT_CONTROL: rd_byte = int_ctrl_reg;
      `USS_OFS_FLAGS_ONE:         rd_byte = flags_view;
      `USS_OFS_ENABLES_ONE:       rd_byte = enables_reg;
      `USS_OFS_PRIORITY_ONE:      rd_byte = priority_reg;
      `USS_OFS_RX_STATUS_CONTROL: rd_byte = rxc_view;
      `USS_OFS_TX_HOLDING_BUFFER: rd_byte = hold_reg;
      `USS_OFS_TX_STATUS_CONTROL: rd_byte = txc_view;
      `USS_OFS_BIT_RATE_DIVISOR:  rd_byte = divisor_reg;
      `USS_OFS_RECEIVE_BUFFER:    rd_byte = rx_buf_reg;
      default:                    rd_byte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Avalon answer: one wait cycle, then a single ready cycle
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= `USS_RESP_OKAY;
    end
    else
    begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest)
      begin
        avs_readdata <= {24'h00_0000, rd_byte};
        avs_response <= mapped ? `USS_RESP_OKAY : `USS_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pins and interrupt outputs
  // --------------------------------------------------------------------------
  wire tx_pend = tx_empty_flag_reg & enables_reg[`USS_TX_EMPTY_BIT];
  wire rx_pend = rx_flag_reg & enables_reg[`USS_RX_COMPLETE_BIT];

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ck_out   <= 1'b0;
      ck_oe    <= 1'b0;
      dt_out   <= 1'b0;
      dt_oe    <= 1'b0;
      wake_req <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      ck_out   <= 1'b0;
      ck_oe    <= 1'b0;
      dt_out   <= tsr_reg[0];
      dt_oe    <= tx_on & tsr_full_reg;
      // Wake needs only the peripheral enable; vectoring needs both
      // global enables as well.
      wake_req <= tx_pend | rx_pend;
      irq      <= (tx_pend | rx_pend)
                & int_ctrl_reg[`USS_GLOBAL_INT_EN_BIT]
                & int_ctrl_reg[`USS_PERIPH_INT_EN_BIT];
    end
  end

endmodule // uss_slave_port

// ===== test/uss_slave_port_checker.sv
// Port checker for the synchronous slave serial port, bound to its top.
// Assumes one clock domain and the registered bus answer of one wait cycle.
`timescale 1ns/100ps

module uss_slave_port_checker
(
  input wire        clk,
  input wire        rst_b,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  input wire        ck_in,
  input wire        ck_out,
  input wire        ck_oe,
  input wire        dt_out,
  input wire        dt_oe,
  input wire        wake_req,
  input wire        irq
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_ck_never_driven;
    ck_oe == 1'b0 && ck_out == 1'b0;
  endproperty
  a_ck_never_driven: assert property (p_ck_never_driven)
    else $error("shift clock pin driven");

  property p_take;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_take: assert property (p_take)
    else $error("request not answered after one wait cycle");

  property p_answer_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_answer_once: assert property (p_answer_once)
    else $error("waitrequest low for more than one cycle");

  property p_unmapped;
    avs_read && avs_waitrequest && avs_address > 6'h20
      |=> avs_response == 2'h2 && avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");

  property p_mapped_ok;
    avs_read && avs_waitrequest && avs_address <= 6'h20
      && avs_address[1:0] == 2'h0 |=> avs_response == 2'h0;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped read refused");

  property p_upper_zero;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits set");

  property p_irq_needs_wake;
    irq |-> wake_req;
  endproperty
  a_irq_needs_wake: assert property (p_irq_needs_wake)
    else $error("interrupt without wake term");

  property p_bit_on_fall;
    dt_oe && $past(dt_oe) && dt_out != $past(dt_out) |-> !ck_in;
  endproperty
  a_bit_on_fall: assert property (p_bit_on_fall)
    else $error("data bit moved outside a shift clock low phase");

  property p_release_on_fall;
    $fell(dt_oe) |-> !ck_in;
  endproperty
  a_release_on_fall: assert property (p_release_on_fall)
    else $error("data pin released outside a shift clock low phase");
endmodule // uss_slave_port_checker

bind uss_slave_port uss_slave_port_checker u_chk
(
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .ck_in(ck_in), .ck_out(ck_out),
  .ck_oe(ck_oe), .dt_out(dt_out), .dt_oe(dt_oe),
  .wake_req(wake_req), .irq(irq)
);

// ===== test/uss_master_model.sv
// External synchronous master: makes the shift clock and data of a frame.
// Assumes the bench resolves the shared data line from the device enable.
`timescale 1ns/100ps

module uss_master_model
(
  output reg       ck,
  output reg       dt,
  input  wire      line,
  output reg [8:0] got,
  output reg       done
);
  initial
  begin
    ck = 1'b1;
    dt = 1'b0;
    got = 9'h000;
    done = 1'b0;
  end

  // The clock idles high and runs only inside a frame; the released data
  // line shows the inverse of its last value so no stale bit can pass.
  task frame(input [8:0] w, input [3:0] n);
    integer i;
    begin
      got = 9'h000;
      #1.3;
      for (i = 0; i < n; i = i + 1)
      begin
        dt = w[i];
        #80 ck = 1'b0;
        got[i] = line;
        #80 ck = 1'b1;
      end
      dt = ~dt;
      done = 1'b1;
      #4 done = 1'b0;
    end
  endtask
endmodule // uss_master_model

// ===== test/test_usart_sync_slave.sv
// Self-checking bench for the synchronous slave serial port.
// Assumes the external master model drives the shift clock pin.
`timescale 1ns/100ps
`include "uss_defines.vh"

module test_usart_sync_slave;
  reg          clk;
  reg          rst_b;
  reg  [5:0]   avs_address;
  reg          avs_read;
  reg          avs_write;
  reg  [31:0]  avs_writedata;
  reg  [31:0]  r;
  wire [31:0]  avs_readdata;
  wire [1:0]   avs_response;
  wire [8:0]   m_got;
  wire         avs_waitrequest, m_ck, m_dt, m_done, ck_out, ck_oe;
  wire         dt_out, dt_oe, wake_req, irq;
  wire         ck_line = ck_oe ? ck_out : m_ck;
  wire         dt_line = dt_oe ? dt_out : m_dt;
  logic [10:0] exp_q[$];
  integer      err_count, total_checks, i;

  uss_slave_port dut
  (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .ck_in(ck_line), .ck_out(ck_out),
    .ck_oe(ck_oe), .dt_in(dt_line), .dt_out(dt_out), .dt_oe(dt_oe),
    .wake_req(wake_req), .irq(irq)
  );

  uss_master_model u_mst
  (
    .ck(m_ck), .dt(m_dt), .line(dt_line), .got(m_got), .done(m_done)
  );

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task check(input string what, input [10:0] seen, input [10:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // The request is held until the edge at which waitrequest is seen low.
  task bus(input [5:0] a, input w, input [7:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task wr(input [5:0] a, input [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task rd(input [5:0] a, input [1:0] resp, input [7:0] e);
    begin
      exp_q.push_back({resp, 1'b0, e});
      bus(a, 1'b0, 8'h00);
    end
  endtask

  // On a transmit frame the model drives the inverse, so a device that
  // fails to drive the line cannot match by accident.
  task fr(input [8:0] w, input [3:0] n, input tx);
    begin
      exp_q.push_back({2'h0, w});
      u_mst.frame(tx ? ~w : w, n);
    end
  endtask

  task pins(input exp_wake, input exp_irq);
    begin
      check("wake_req", {10'h0, wake_req}, {10'h0, exp_wake});
      check("irq", {10'h0, irq}, {10'h0, exp_irq});
    end
  endtask

  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check("read", {avs_response, 1'b0, avs_readdata[7:0]},
            exp_q.pop_front());

  always @(posedge m_done)
    check("frame", {2'h0, m_got}, exp_q.pop_front());

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #200000;
    err_count = err_count + 1;
    summarize;
  end

  initial
  begin
    rst_b = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_count = 0;
    total_checks = 0;
    r = $urandom(32'ha0a4);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 10; i = i + 1)
      rd(6'(i * 4), (i == 9) ? 2'h2 : 2'h0, (i == 6) ? 8'h02 : 8'h00);
    $display("test reset values done");
    wr(`USS_OFS_RX_STATUS_CONTROL, 8'h80);
    wr(`USS_OFS_TX_STATUS_CONTROL, 8'h30);
    wr(`USS_OFS_ENABLES_ONE, 8'h10);
    rd(`USS_OFS_FLAGS_ONE, 2'h0, 8'h10);
    wr(`USS_OFS_INTERRUPT_CONTROL, 8'hc0);
    repeat (2) @(posedge clk);
    pins(1'b1, 1'b1);
    r = $urandom;
    wr(`USS_OFS_TX_HOLDING_BUFFER, r[7:0]);
    wr(`USS_OFS_TX_HOLDING_BUFFER, r[15:8]);
    rd(`USS_OFS_FLAGS_ONE, 2'h0, 8'h00);
    rd(`USS_OFS_TX_STATUS_CONTROL, 2'h0, 8'h30);
    pins(1'b0, 1'b0);
    fr({1'b0, r[7:0]}, 4'h8, 1'b1);
    rd(`USS_OFS_FLAGS_ONE, 2'h0, 8'h10);
    fr({1'b0, r[15:8]}, 4'h8, 1'b1);
    repeat (10) @(posedge clk);
    rd(`USS_OFS_TX_STATUS_CONTROL, 2'h0, 8'h32);
    wr(`USS_OFS_TX_STATUS_CONTROL, 8'h71);
    wr(`USS_OFS_TX_HOLDING_BUFFER, r[23:16]);
    fr({1'b1, r[23:16]}, 4'h9, 1'b1);
    $display("test transmit done");
    wr(`USS_OFS_TX_STATUS_CONTROL, 8'h10);
    wr(`USS_OFS_ENABLES_ONE, 8'h20);
    wr(`USS_OFS_RX_STATUS_CONTROL, 8'hb0);
    fr({1'b0, r[31:24]}, 4'h8, 1'b0);
    repeat (10) @(posedge clk);
    rd(`USS_OFS_FLAGS_ONE, 2'h0, 8'h20);
    pins(1'b1, 1'b1);
    rd(`USS_OFS_RX_STATUS_CONTROL, 2'h0, 8'hb0);
    rd(`USS_OFS_RECEIVE_BUFFER, 2'h0, r[31:24]);
    rd(`USS_OFS_FLAGS_ONE, 2'h0, 8'h00);
    $display("test receive done");
    r = $urandom;
    wr(`USS_OFS_RX_STATUS_CONTROL, 8'hd0);
    fr({1'b1, r[7:0]}, 4'h9, 1'b0);
    fr({1'b0, r[15:8]}, 4'h9, 1'b0);
    repeat (10) @(posedge clk);
    rd(`USS_OFS_RX_STATUS_CONTROL, 2'h0, 8'hd3);
    rd(`USS_OFS_RECEIVE_BUFFER, 2'h0, r[7:0]);
    wr(`USS_OFS_RX_STATUS_CONTROL, 8'hc0);
    wr(`USS_OFS_RX_STATUS_CONTROL, 8'hd0);
    fr({1'b0, r[23:16]}, 4'h9, 1'b0);
    repeat (10) @(posedge clk);
    rd(`USS_OFS_RX_STATUS_CONTROL, 2'h0, 8'hd0);
    rd(`USS_OFS_RECEIVE_BUFFER, 2'h0, r[23:16]);
    $display("test overrun recovery done");
    wr(`USS_OFS_RX_STATUS_CONTROL, 8'ha0);
    fr({1'b0, r[31:24]}, 4'h8, 1'b0);
    repeat (10) @(posedge clk);
    rd(`USS_OFS_FLAGS_ONE, 2'h0, 8'h00);
    $display("test single receive ignored done");
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`USS_OFS_RX_STATUS_CONTROL, 2'h0, 8'h00);
    rd(`USS_OFS_TX_STATUS_CONTROL, 2'h0, 8'h02);
    pins(1'b0, 1'b0);
    $display("test mid-run reset done");
    summarize;
  end
endmodule // test_usart_sync_slave
